// [common/apt_pkg.sv]
// constants and types for the converter pair trigger control block
package apt_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] OFF_PAIR_CTRL_1 = 8'h00;
  localparam logic [7:0] OFF_PAIR_CTRL_2 = 8'h04;
  localparam logic [7:0] OFF_PAIR_CTRL_3 = 8'h08;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFF_GLOBAL_TRIG = 8'h14;
  localparam logic [7:0] OFF_ENGINE_STATUS = 8'h18;

  // field positions inside one pair byte
  localparam int SEL_LSB = 0;
  localparam int SEL_W = 5;
  localparam int SOFT_BIT = 5;
  localparam int PEND_BIT = 6;
  localparam int IRQEN_BIT = 7;
  localparam int BYTE_W = 8;
  localparam int PAIRS_PER_REG = 2;

  // number of the first pair held here; pairs below it live elsewhere
  localparam int FIRST_PAIR = 2;
  localparam int MAX_PAIRS = 5;

  // bit of the global trigger register and engine status fields
  localparam int GLOBAL_TRIG_BIT = 0;
  localparam int ENG_BUSY_BIT = 0;
  localparam int ENG_PAIR_LSB = 4;

  // reset values
  localparam logic [7:0] PAIR_BYTE_RST = 8'h00;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // trigger source selector codes
  localparam logic [4:0] TRG_OFF = 5'h00;
  localparam logic [4:0] TRG_SOFT_OWN = 5'h01;
  localparam logic [4:0] TRG_SOFT_GLOBAL = 5'h02;
  localparam logic [4:0] TRG_PWM_SPECIAL = 5'h03;
  localparam logic [4:0] TRG_PWM_PRI_1 = 5'h04;
  localparam logic [4:0] TRG_TMR1 = 5'h0C;
  localparam logic [4:0] TRG_PWM_SEC_1 = 5'h0E;
  localparam logic [4:0] TRG_PWM_CL_1 = 5'h17;
  localparam logic [4:0] TRG_TMR2 = 5'h1F;
  localparam int NUM_PWM_GEN = 4;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_REQ,
    ST_BUSY
  } apt_state_t;

endpackage

// [core/apt_pair_trigger.sv]
// converter pair trigger control: selectors, pending flags, arbiter and apb registers
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps

// Contract
// - each pair has a 5-bit trigger selector; code zero disables the pair
// - code 1 picks the pair's own soft trigger, code 2 the global one
// - code 3 picks pwm special event; codes 4-7 pwm generator 1-4 primary
// - codes 14-17 hex 0E-11 pick pwm generator 1-4 secondary triggers
// - codes hex 17-1A pick pwm generator 1-4 current-limit triggers
// - code hex 0C starts on timer 1 period, hex 1F on timer 2 period
// - selected trigger sets pending; completion of the conversion clears it
// - soft trigger bit clears itself when pending gets set
// - soft trigger bit starts conversion only with a software selector
// - triggers for other pairs wait while the converter is busy; a trigger on a still-pending pair is dropped
// - with irq enable set, completion sets the status bit; irq rises only if the mask bit is also set
// - each register holds two pairs, odd pair high byte, even low byte
// - upper byte of the last pair's register is absent and reads zero
// - the last pair converts the internal and external reference inputs
module apt_pair_trigger #(
  parameter int NPAIR = apt_pkg::MAX_PAIRS
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // trigger events, one-cycle pulses from on-chip logic
  input wire logic pwm_special_trig,
  input wire logic [3:0] pwm_primary_trig,
  input wire logic [3:0] pwm_secondary_trig,
  input wire logic [3:0] pwm_climit_trig,
  input wire logic timer1_period_match,
  input wire logic timer2_period_match,
  // converter core handshake
  output logic conv_req,
  output logic [2:0] conv_pair,
  output logic conv_ref_inputs,
  input wire logic conv_ready,
  input wire logic conv_done,
  // interrupt
  output logic irq
);

  // refused at elaboration: the pair count must fit the register slots
  if (NPAIR < 1 || NPAIR > apt_pkg::MAX_PAIRS) begin : g_bad_npair
    $error("NPAIR must lie between 1 and the number of register slots");
  end

  localparam int PW = apt_pkg::SEL_W;

  // per-pair control state
  logic [PW-1:0] sel_r [NPAIR];
  logic [NPAIR-1:0] soft_r;
  logic [NPAIR-1:0] pend_r;
  logic [NPAIR-1:0] irqen_r;
  logic [NPAIR-1:0] sts_r;
  logic [NPAIR-1:0] mask_r;

  // engine state
  apt_pkg::apt_state_t state_r;
  logic [2:0] cur_r;
  logic conv_req_r;
  logic [2:0] conv_pair_r;
  logic conv_ref_r;
  logic irq_r;

  // bus state
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] rd_nxt;
  logic addr_ok;

  // bus decode, trigger sources, arbiter pick and interrupt set nets
  logic setup_ph;
  logic wr_take;
  logic global_trig;
  logic [NPAIR-1:0] done_vec;
  logic [NPAIR-1:0] hit;
  logic [NPAIR-1:0] wr_byte;
  logic [NPAIR-1:0] wr_soft_one;
  logic [31:0] src_vec [NPAIR];
  logic [2:0] pick;
  logic pick_ok;
  logic [NPAIR-1:0] set_sts;

  assign setup_ph = psel & ~penable;
  // a write lands only on the edge where the slave shows pready
  assign wr_take = psel & penable & pready_r & pwrite & ~pslverr_r;

  assign global_trig = wr_take && (paddr == apt_pkg::OFF_GLOBAL_TRIG) &&
                       pstrb[0] && pwdata[apt_pkg::GLOBAL_TRIG_BIT];

  // register that belongs to pair p
  function automatic logic [7:0] pair_off(input int p);
    case (p / apt_pkg::PAIRS_PER_REG)
      0: pair_off = apt_pkg::OFF_PAIR_CTRL_1;
      1: pair_off = apt_pkg::OFF_PAIR_CTRL_2;
      default: pair_off = apt_pkg::OFF_PAIR_CTRL_3;
    endcase
  endfunction

  genvar g;
  generate
    for (g = 0; g < NPAIR; g++) begin : g_pair
      localparam int LANE = g % apt_pkg::PAIRS_PER_REG;
      localparam int LSB = LANE * apt_pkg::BYTE_W;

      assign wr_byte[g] = wr_take && (paddr == pair_off(g)) && pstrb[LANE];
      assign wr_soft_one[g] = wr_byte[g] && pwdata[LSB + apt_pkg::SOFT_BIT];
      assign done_vec[g] = conv_done && (state_r == apt_pkg::ST_BUSY) &&
                           (cur_r == 3'(g));

      // source table indexed by selector code; reserved codes stay low
      always_comb begin
        src_vec[g] = 32'h0000_0000;
        src_vec[g][apt_pkg::TRG_OFF] = 1'b0;
        src_vec[g][apt_pkg::TRG_SOFT_OWN] = soft_r[g];
        // the own soft bit also fires under the global code
        src_vec[g][apt_pkg::TRG_SOFT_GLOBAL] = global_trig | soft_r[g];
        src_vec[g][apt_pkg::TRG_PWM_SPECIAL] = pwm_special_trig;
        for (int k = 0; k < apt_pkg::NUM_PWM_GEN; k++) begin
          src_vec[g][apt_pkg::TRG_PWM_PRI_1 + 5'(k)] = pwm_primary_trig[k];
          src_vec[g][apt_pkg::TRG_PWM_SEC_1 + 5'(k)] = pwm_secondary_trig[k];
          src_vec[g][apt_pkg::TRG_PWM_CL_1 + 5'(k)] = pwm_climit_trig[k];
        end
        src_vec[g][apt_pkg::TRG_TMR1] = timer1_period_match;
        src_vec[g][apt_pkg::TRG_TMR2] = timer2_period_match;
      end

      // a trigger on a pending pair is absorbed unless its completion falls in the same cycle
      assign hit[g] = src_vec[g][sel_r[g]] & ~(pend_r[g] & ~done_vec[g]);

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sel_r[g] <= apt_pkg::PAIR_BYTE_RST[PW-1:0];
          irqen_r[g] <= 1'b0;
        end else if (wr_byte[g]) begin
          sel_r[g] <= pwdata[LSB +: PW];
          irqen_r[g] <= pwdata[LSB + apt_pkg::IRQEN_BIT];
        end
      end

      // pending: set on hit, cleared by completion; the set wins
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pend_r[g] <= 1'b0;
        end else if (hit[g]) begin
          pend_r[g] <= 1'b1;
        end else if (done_vec[g]) begin
          pend_r[g] <= 1'b0;
        end
      end

      // soft bit: a fresh write of one beats the self-clear
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          soft_r[g] <= 1'b0;
        end else if (wr_soft_one[g]) begin
          soft_r[g] <= 1'b1;
        end else if (hit[g] || wr_byte[g]) begin
          soft_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // lowest pair number wins; others stay pending until the engine frees
  always_comb begin
    pick = 3'h0;
    pick_ok = 1'b0;
    for (int p = NPAIR - 1; p >= 0; p--) begin
      if (pend_r[p]) begin
        pick = 3'(p);
        pick_ok = 1'b1;
      end
    end
  end

  // request engine: one conversion outstanding at a time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= apt_pkg::ST_IDLE;
      cur_r <= 3'h0;
    end else begin
      case (state_r)
        apt_pkg::ST_IDLE: begin
          if (pick_ok) begin
            state_r <= apt_pkg::ST_REQ;
            cur_r <= pick;
          end
        end
        apt_pkg::ST_REQ: begin
          // held off while the core is still converting something else
          if (conv_ready) begin
            state_r <= apt_pkg::ST_BUSY;
          end
        end
        apt_pkg::ST_BUSY: begin
          if (conv_done) begin
            state_r <= apt_pkg::ST_IDLE;
          end
        end
        default: begin
          state_r <= apt_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // converter request outputs straight from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_req_r <= 1'b0;
      conv_pair_r <= 3'h0;
      conv_ref_r <= 1'b0;
    end else if (state_r == apt_pkg::ST_IDLE && pick_ok) begin
      conv_req_r <= 1'b1;
      conv_pair_r <= 3'(pick + 3'(apt_pkg::FIRST_PAIR));
      // the last slot samples the two reference inputs, not pins
      conv_ref_r <= (pick == 3'(NPAIR - 1));
    end else if (state_r == apt_pkg::ST_REQ && conv_ready) begin
      conv_req_r <= 1'b0;
    end
  end

  // interrupt status: sticky, write one to clear, set wins
  always_comb begin
    for (int p = 0; p < NPAIR; p++) begin
      set_sts[p] = done_vec[p] & irqen_r[p];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_r <= '0;
    end else if (wr_take && paddr == apt_pkg::OFF_IRQ_STATUS && pstrb[0]) begin
      sts_r <= (sts_r & ~pwdata[NPAIR-1:0]) | set_sts;
    end else begin
      sts_r <= sts_r | set_sts;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= '0;
    end else if (wr_take && paddr == apt_pkg::OFF_IRQ_MASK && pstrb[0]) begin
      mask_r <= pwdata[NPAIR-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |((sts_r | set_sts) & mask_r);
    end
  end

  // read mux; absent lanes read zero
  always_comb begin
    rd_nxt = 32'h0000_0000;
    addr_ok = 1'b1;
    case (paddr)
      apt_pkg::OFF_PAIR_CTRL_1, apt_pkg::OFF_PAIR_CTRL_2,
      apt_pkg::OFF_PAIR_CTRL_3: begin
        for (int p = 0; p < NPAIR; p++) begin
          if (paddr == pair_off(p)) begin
            // unfilled upper byte of the last register stays zero
            rd_nxt[(p % apt_pkg::PAIRS_PER_REG) * apt_pkg::BYTE_W +: apt_pkg::BYTE_W] =
              {irqen_r[p], pend_r[p], soft_r[p], sel_r[p]};
          end
        end
      end
      apt_pkg::OFF_IRQ_STATUS: rd_nxt[NPAIR-1:0] = sts_r;
      apt_pkg::OFF_IRQ_MASK: rd_nxt[NPAIR-1:0] = mask_r;
      apt_pkg::OFF_GLOBAL_TRIG: rd_nxt = 32'h0000_0000;
      apt_pkg::OFF_ENGINE_STATUS: begin
        rd_nxt[apt_pkg::ENG_BUSY_BIT] = (state_r != apt_pkg::ST_IDLE);
        rd_nxt[apt_pkg::ENG_PAIR_LSB +: 3] = 3'(cur_r + 3'(apt_pkg::FIRST_PAIR));
      end
      default: addr_ok = 1'b0;
    endcase
  end

  // apb answer: one access cycle, data and error set up during setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= apt_pkg::RDATA_RST;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else if (setup_ph) begin
      prdata_r <= pwrite ? apt_pkg::RDATA_RST : rd_nxt;
      pready_r <= 1'b1;
      pslverr_r <= ~addr_ok;
    end else begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign conv_req = conv_req_r;
  assign conv_pair = conv_pair_r;
  assign conv_ref_inputs = conv_ref_r;
  assign irq = irq_r;

endmodule

// [testbench/apt_conv_model.sv]
// converter core model: accepts requests and reports completion
`timescale 1ns/1ps
module apt_conv_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // request side
  input wire logic conv_req,
  input wire logic conv_ref_inputs,
  input wire logic slow,
  output logic conv_ready,
  output logic conv_done,
  // observation
  output logic [7:0] accepts,
  output logic ref_seen
);
  logic busy;
  logic [4:0] cnt;
  logic [1:0] wcnt;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_ready <= 1'b0;
      conv_done <= 1'b0;
      busy <= 1'b0;
      cnt <= 5'h00;
      wcnt <= 2'h0;
      accepts <= 8'h00;
      ref_seen <= 1'b0;
    end else begin
      conv_done <= 1'b0;
      if (busy) begin
        if (cnt == 5'h00) begin
          conv_done <= 1'b1;
          busy <= 1'b0;
          wcnt <= slow ? 2'h3 : 2'h0;
        end else cnt <= cnt - 5'h01;
      end else if (conv_req && conv_ready) begin
        // a slow core keeps the pair pending long enough that a second trigger is absorbed
        busy <= 1'b1;
        conv_ready <= 1'b0;
        cnt <= slow ? 5'h14 : 5'h04;
        accepts <= accepts + 8'h01;
        ref_seen <= ref_seen | conv_ref_inputs;
      end else if (conv_req) begin
        if (wcnt == 2'h0) conv_ready <= 1'b1;
        else wcnt <= wcnt - 2'h1;
      end
    end
  end
endmodule

// [testbench/apt_pair_trigger_asserts.sv]
// port checker for the pair trigger control block
`timescale 1ns/1ps
module apt_pair_trigger_chk #(
  parameter int NPAIR = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  input wire logic conv_req,
  input wire logic [2:0] conv_pair,
  input wire logic conv_ref_inputs,
  input wire logic conv_ready,
  input wire logic conv_done,
  input wire logic pwrite,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  reset_quiet_a: assert property ($rose(presetn) |-> !conv_req && !irq && !pready)
    else $error("outputs not idle after reset");
  req_hold_a: assert property (conv_req && !conv_ready |=> conv_req && $stable(conv_pair))
    else $error("request dropped before accept");
  req_once_a: assert property (conv_req && conv_ready |=> !conv_req)
    else $error("request held after accept");
  ref_last_a: assert property (conv_req |-> conv_ref_inputs == (conv_pair == 2 + NPAIR - 1))
    else $error("reference flag wrong for pair");
  pair_range_a: assert property (conv_req |-> conv_pair >= 2 && conv_pair < 2 + NPAIR)
    else $error("request for absent pair");
  // a waiting pair may be requested two cycles after completion, not sooner
  done_gap_a: assert property (conv_done |=> !conv_req)
    else $error("request too soon after completion");
  // completion raises irq one edge later, a mask write two edges later
  irq_cause_a: assert property ($rose(irq) |-> $past(conv_done) ||
    $past(psel && penable && pwrite, 2))
    else $error("interrupt without cause");
  apb_access_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("access phase not one cycle");
  err_data_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("unmapped access returned data");
endmodule
bind apt_pair_trigger apt_pair_trigger_chk #(.NPAIR(NPAIR)) u_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .prdata(prdata), .conv_req(conv_req), .conv_pair(conv_pair), .conv_ready(conv_ready),
  .conv_ref_inputs(conv_ref_inputs), .conv_done(conv_done), .pwrite(pwrite), .irq(irq));

// [testbench/tb_top.sv]
// register level testbench for the pair trigger control block
`timescale 1ns/1ps
module tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [3:0] pstrb = 4'h0, pri = 4'h0, sec = 4'h0, cl = 4'h0;
  logic pready, pslverr, spec = 0, t1 = 0, t2 = 0, e, conv_req, conv_ref, rdy, done, irq, refs;
  logic [2:0] conv_pair;
  logic [7:0] acc, n0;
  logic [4:0] codes [0:21] = '{5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h0C, 5'h0E, 5'h0F,
    5'h10, 5'h11, 5'h17, 5'h18, 5'h19, 5'h1A, 5'h1F, 5'h00, 5'h08, 5'h0D, 5'h12, 5'h13,
    5'h16, 5'h1B};
  int err_count = 0, cmp_count = 0;
  always #12.5 pclk = ~pclk;
  apt_pair_trigger u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pwm_special_trig(spec), .pwm_primary_trig(pri),
    .pwm_secondary_trig(sec), .pwm_climit_trig(cl), .timer1_period_match(t1),
    .timer2_period_match(t2), .conv_req(conv_req), .conv_pair(conv_pair),
    .conv_ref_inputs(conv_ref), .conv_ready(rdy), .conv_done(done), .irq(irq));
  apt_conv_model u_core (.pclk(pclk), .presetn(presetn), .conv_req(conv_req),
    .conv_ref_inputs(conv_ref), .slow(slow), .conv_ready(rdy), .conv_done(done),
    .accepts(acc), .ref_seen(refs));
  task stop_test;
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge pclk);
    penable <= 1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    // the answer is taken at the edge that shows pready, then the bus lets go
    if (n >= 50) begin
      err_count++;
      $display("[FAIL] %0t no pready on access", $time);
    end
    r = prdata; e = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task fire(input logic [4:0] c, input logic all);
    @(posedge pclk);
    spec <= all || c == 5'h03; t1 <= all || c == 5'h0C; t2 <= all || c == 5'h1F;
    for (int k = 0; k < 4; k++) begin
      pri[k] <= all || c == 5'h04 + k;
      sec[k] <= all || c == 5'h0E + k;
      cl[k] <= all || c == 5'h17 + k;
    end
    @(posedge pclk);
    spec <= 0; t1 <= 0; t2 <= 0; pri <= 4'h0; sec <= 4'h0; cl <= 4'h0;
  endtask
  initial begin
    #(25 * 20000);
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    stop_test;
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    for (int i = 0; i < 16; i += 4) begin apb(0, i, 0, 4'hF); chk(r, 0); end
    $display("reset values done");
    for (int i = 0; i < 22; i++) begin
      apb(1, apt_pkg::OFF_PAIR_CTRL_1, {27'h0, codes[i]}, 4'h1);
      fire(codes[i], i >= 15);
      apb(0, apt_pkg::OFF_PAIR_CTRL_1, 0, 4'hF);
      chk(r, {25'h0, i < 15, 1'b0, codes[i]});
      repeat (40) @(posedge pclk);
    end
    $display("selector table done");
    apb(1, apt_pkg::OFF_IRQ_MASK, 32'h2, 4'hF);
    apb(1, apt_pkg::OFF_PAIR_CTRL_1, 32'h0000_A100, 4'h2);
    apb(0, apt_pkg::OFF_PAIR_CTRL_1, 0, 4'hF); chk(r, 32'h0000_C11B);
    repeat (40) @(posedge pclk);
    apb(0, apt_pkg::OFF_PAIR_CTRL_1, 0, 4'hF); chk(r, 32'h0000_811B);
    chk({31'h0, irq}, 1);
    apb(0, apt_pkg::OFF_IRQ_STATUS, 0, 4'hF); chk(r, 32'h2);
    apb(1, apt_pkg::OFF_IRQ_STATUS, 32'h2, 4'hF);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 0);
    apb(1, apt_pkg::OFF_PAIR_CTRL_2, 32'h0000_0224, 4'h3);
    apb(1, apt_pkg::OFF_GLOBAL_TRIG, 32'h1, 4'hF);
    apb(0, apt_pkg::OFF_PAIR_CTRL_2, 0, 4'hF); chk(r, 32'h0000_4224);
    repeat (40) @(posedge pclk);
    apb(1, apt_pkg::OFF_PAIR_CTRL_2, 32'h0, 4'h3);
    $display("soft trigger done");
    apb(1, apt_pkg::OFF_PAIR_CTRL_3, 32'hFFFF_000C, 4'hF);
    apb(1, apt_pkg::OFF_PAIR_CTRL_1, 32'h0000_000C, 4'h1);
    apb(0, apt_pkg::OFF_PAIR_CTRL_3, 0, 4'hF); chk(r, 32'h0000_000C);
    n0 = acc;
    fire(5'h0C, 0);
    repeat (3) @(posedge pclk);
    fire(5'h0C, 0);
    repeat (100) @(posedge pclk);
    chk(acc - n0, 2);
    chk({31'h0, refs}, 1);
    slow <= 0;
    fire(5'h0C, 0);
    repeat (40) @(posedge pclk);
    chk(acc - n0, 4);
    // engine idle, last served slot is the reference pair
    apb(0, apt_pkg::OFF_ENGINE_STATUS, 0, 4'hF);
    chk(r, 32'h0000_0060);
    apb(0, 8'h40, 0, 4'hF); chk({31'h0, e}, 1); chk(r, 0);
    $display("deferral done");
    stop_test;
  end
endmodule
